// File: aux_timer_pkg.sv
// constants for the auxiliary timer reload and capture block
package aux_timer_pkg;
    localparam int TIMER_W = 16;
    localparam logic [15:0] TIMER_MAX = 16'hFFFF;
    localparam logic [15:0] TIMER_RST = 16'h0000;
    // block prescale codes, non-linear
    localparam logic [1:0] BPS_DIV4 = 2'h1;
    localparam logic [1:0] BPS_DIV8 = 2'h0;
    localparam logic [1:0] BPS_DIV16 = 2'h3;
    localparam logic [1:0] BPS_DIV32 = 2'h2;
    localparam logic [1:0] BPS_RST = BPS_DIV8;
    // terminal counts of the basic clock divider (factor - 1)
    localparam logic [4:0] BDIV_LAST4 = 5'h03;
    localparam logic [4:0] BDIV_LAST8 = 5'h07;
    localparam logic [4:0] BDIV_LAST16 = 5'h0F;
    localparam logic [4:0] BDIV_LAST32 = 5'h1F;
    localparam int PRESC_W = 7;
    // auxiliary mode codes
    localparam logic [2:0] MODE_TIMER = 3'h0;
    localparam logic [2:0] MODE_RELOAD = 3'h4;
    localparam logic [2:0] MODE_CAPTURE = 3'h5;
    // input select: in reload mode bit 2 picks the toggle latch, low bits the edge
    localparam int SEL_SRC_BIT = 2;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_ANY = 2'h3;
endpackage

// File: aux_timer_reload_capture.sv
// core timer with two auxiliary timers: basic clock, reload and capture
`timescale 1ns/100ps
`default_nettype none
module aux_timer_reload_capture (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // core control
    input wire logic [1:0] block_prescale_field,
    input wire logic [2:0] core_input_select,
    input wire logic core_run,
    input wire logic core_count_down,
    input wire logic core_output_enable,
    // auxiliary control, index 0 first, 1 second
    input wire logic [2:0] first_aux_mode_field,
    input wire logic [2:0] first_aux_input_select_field,
    input wire logic first_aux_run_flag,
    input wire logic [2:0] second_aux_mode_field,
    input wire logic [2:0] second_aux_input_select_field,
    input wire logic second_aux_run_flag,
    // software writes
    input wire logic core_wr,
    input wire logic [15:0] core_wdata,
    input wire logic first_aux_wr,
    input wire logic [15:0] first_aux_wdata,
    input wire logic second_aux_wr,
    input wire logic [15:0] second_aux_wdata,
    input wire logic latch_wr,
    input wire logic latch_wdata,
    // irq flag clears
    input wire logic core_irq_clr,
    input wire logic first_aux_irq_clr,
    input wire logic second_aux_irq_clr,
    // pins
    input wire logic first_aux_input_pin,
    input wire logic second_aux_input_pin,
    output logic core_toggle_output_pin,
    // state
    output logic [15:0] core_timer,
    output logic [15:0] first_aux_timer,
    output logic [15:0] second_aux_timer,
    output logic core_toggle_latch,
    output logic core_irq_flag,
    output logic first_aux_irq_flag,
    output logic second_aux_irq_flag
);
    logic [4:0] bdiv_ff;
    logic [4:0] bdiv_last;
    logic basic_tick_ff;
    logic [6:0] presc_ff;
    logic [1:0] pin_s1_ff;
    logic [1:0] pin_s2_ff;
    logic [1:0] samp_ff;
    logic [1:0] prev_ff;
    logic [1:0] pend_ff;
    logic [1:0] pend_latch_ff;
    logic [1:0] trig;
    logic [1:0] apply_reload;
    logic [1:0] apply_capture;
    logic [1:0] aux_cnt;
    logic [2:0] mode [2];
    logic [2:0] sel [2];
    logic [1:0] run;
    logic core_cnt_en;
    logic core_ovf;
    logic otl_rise;
    logic otl_fall;
    logic reload_latch;

    function automatic logic presc_hit(input logic [6:0] cnt, input logic [2:0] s);
        logic [6:0] m;
        m = 7'((8'h01 << s) - 8'h01);
        return (cnt & m) == m;
    endfunction

    function automatic logic edge_hit(input logic [1:0] e, input logic r, input logic f);
        logic h;
        h = 1'b0;
        case (e)
            aux_timer_pkg::EDGE_RISE: h = r;
            aux_timer_pkg::EDGE_FALL: h = f;
            aux_timer_pkg::EDGE_ANY: h = r | f;
            default: h = 1'b0;
        endcase
        return h;
    endfunction

    assign mode[0] = first_aux_mode_field;
    assign mode[1] = second_aux_mode_field;
    assign sel[0] = first_aux_input_select_field;
    assign sel[1] = second_aux_input_select_field;
    assign run = {second_aux_run_flag, first_aux_run_flag};

    // basic clock divider
    always_comb
    begin
        case (block_prescale_field)
            aux_timer_pkg::BPS_DIV4: bdiv_last = aux_timer_pkg::BDIV_LAST4;
            aux_timer_pkg::BPS_DIV16: bdiv_last = aux_timer_pkg::BDIV_LAST16;
            aux_timer_pkg::BPS_DIV32: bdiv_last = aux_timer_pkg::BDIV_LAST32;
            default: bdiv_last = aux_timer_pkg::BDIV_LAST8;
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            bdiv_ff <= '0;
            basic_tick_ff <= 1'b0;
        end
        else if (bdiv_ff >= bdiv_last)
        begin
            bdiv_ff <= '0;
            basic_tick_ff <= 1'b1;
        end
        else
        begin
            bdiv_ff <= bdiv_ff + 5'h01;
            basic_tick_ff <= 1'b0;
        end
    end

    // shared input prescaler, counts basic ticks
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            presc_ff <= '0;
        else if (basic_tick_ff)
            presc_ff <= presc_ff + 7'h01;
    end

    // pins: two-stage synchroniser, then basic clock sampling
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
        end
        else
        begin
            pin_s1_ff <= {second_aux_input_pin, first_aux_input_pin};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            samp_ff <= '0;
            prev_ff <= '0;
        end
        else if (basic_tick_ff)
        begin
            samp_ff <= pin_s2_ff;
            prev_ff <= samp_ff;
        end
    end

    // core counting and hardware toggle-latch edges
    assign core_cnt_en = basic_tick_ff && core_run && presc_hit(presc_ff, core_input_select);
    assign core_ovf = core_cnt_en && !core_wr && (apply_reload == 2'b00) &&
        (core_count_down ? core_timer == aux_timer_pkg::TIMER_RST : core_timer == aux_timer_pkg::TIMER_MAX);
    // only overflow makes latch edges; software writes cannot
    assign otl_rise = core_ovf && !core_toggle_latch;
    assign otl_fall = core_ovf && core_toggle_latch;

    // trigger detection per auxiliary timer
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            trig[i] = 1'b0;
            if (mode[i] == aux_timer_pkg::MODE_RELOAD)
            begin
                if (sel[i][aux_timer_pkg::SEL_SRC_BIT])
                    trig[i] = edge_hit(sel[i][1:0], otl_rise, otl_fall);
                else
                    trig[i] = edge_hit(sel[i][1:0], samp_ff[i] & ~prev_ff[i], ~samp_ff[i] & prev_ff[i]);
            end
            else if (mode[i] == aux_timer_pkg::MODE_CAPTURE)
                trig[i] = edge_hit(sel[i][1:0], samp_ff[i] & ~prev_ff[i], ~samp_ff[i] & prev_ff[i]);
            apply_reload[i] = basic_tick_ff && pend_ff[i] && mode[i] == aux_timer_pkg::MODE_RELOAD;
            apply_capture[i] = basic_tick_ff && pend_ff[i] && mode[i] == aux_timer_pkg::MODE_CAPTURE;
            // timer mode only: reload and capture modes stop the timer
            aux_cnt[i] = basic_tick_ff && run[i] && mode[i] == aux_timer_pkg::MODE_TIMER &&
                presc_hit(presc_ff, sel[i]);
        end
    end

    assign reload_latch = (apply_reload[0] && pend_latch_ff[0]) || (apply_reload[1] && pend_latch_ff[1]);

    // pending triggers, replaced every tick so each applies once
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pend_ff <= '0;
            pend_latch_ff <= '0;
        end
        else if (basic_tick_ff)
        begin
            pend_ff <= trig;
            pend_latch_ff <= {sel[1][aux_timer_pkg::SEL_SRC_BIT], sel[0][aux_timer_pkg::SEL_SRC_BIT]};
        end
    end

    // core timer; a software write beats a reload in the same cycle
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            core_timer <= aux_timer_pkg::TIMER_RST;
        else if (core_wr)
            core_timer <= core_wdata;
        else if (apply_reload[1])
            core_timer <= second_aux_timer;
        else if (apply_reload[0])
            core_timer <= first_aux_timer;
        else if (core_cnt_en)
            core_timer <= core_count_down ? core_timer - 16'h0001 : core_timer + 16'h0001;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            core_toggle_latch <= 1'b0;
        else if (core_ovf)
            core_toggle_latch <= ~core_toggle_latch;
        else if (latch_wr)
            core_toggle_latch <= latch_wdata;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            core_toggle_output_pin <= 1'b0;
        else
            core_toggle_output_pin <= core_toggle_latch && core_output_enable;
    end

    // auxiliary registers
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            first_aux_timer <= aux_timer_pkg::TIMER_RST;
        else if (first_aux_wr)
            first_aux_timer <= first_aux_wdata;
        else if (apply_capture[0])
            first_aux_timer <= core_timer;
        else if (aux_cnt[0])
            first_aux_timer <= first_aux_timer + 16'h0001;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            second_aux_timer <= aux_timer_pkg::TIMER_RST;
        else if (second_aux_wr)
            second_aux_timer <= second_aux_wdata;
        else if (apply_capture[1])
            second_aux_timer <= core_timer;
        else if (aux_cnt[1])
            second_aux_timer <= second_aux_timer + 16'h0001;
    end

    // irq flags: a set in the clearing cycle wins
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            core_irq_flag <= 1'b0;
            first_aux_irq_flag <= 1'b0;
            second_aux_irq_flag <= 1'b0;
        end
        else
        begin
            core_irq_flag <= core_ovf || reload_latch || (core_irq_flag && !core_irq_clr);
            first_aux_irq_flag <= apply_reload[0] || apply_capture[0] ||
                (aux_cnt[0] && first_aux_timer == aux_timer_pkg::TIMER_MAX) ||
                (first_aux_irq_flag && !first_aux_irq_clr);
            second_aux_irq_flag <= apply_reload[1] || apply_capture[1] ||
                (aux_cnt[1] && second_aux_timer == aux_timer_pkg::TIMER_MAX) ||
                (second_aux_irq_flag && !second_aux_irq_clr);
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    property p_tick8;
        basic_tick_ff && block_prescale_field == aux_timer_pkg::BPS_DIV8 ##1
        (block_prescale_field == aux_timer_pkg::BPS_DIV8)[*7] |=> basic_tick_ff;
    endproperty
    a_tick8: assert property (p_tick8) else $error("basic tick not every 8 clocks");

    property p_tick_gap;
        basic_tick_ff |=> !basic_tick_ff [*3];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("basic ticks too close");

    property p_reload_hold;
        first_aux_mode_field == aux_timer_pkg::MODE_RELOAD && !first_aux_wr |=> $stable(first_aux_timer);
    endproperty
    a_reload_hold: assert property (p_reload_hold) else $error("reload-mode timer counted");

    property p_reload_first;
        apply_reload == 2'b01 && !core_wr |=> core_timer == $past(first_aux_timer) && first_aux_irq_flag;
    endproperty
    a_reload_first: assert property (p_reload_first) else $error("first reload wrong");

    property p_reload_both;
        apply_reload == 2'b11 && !core_wr |=> core_timer == $past(second_aux_timer);
    endproperty
    a_reload_both: assert property (p_reload_both) else $error("second timer did not win");

    property p_capture;
        apply_capture[1] && !second_aux_wr |=> second_aux_timer == $past(core_timer) && second_aux_irq_flag;
    endproperty
    a_capture: assert property (p_capture) else $error("capture store or flag wrong");

    property p_out_gate;
        !core_output_enable |=> !core_toggle_output_pin;
    endproperty
    a_out_gate: assert property (p_out_gate) else $error("output pin driven while disabled");

    property p_sw_latch;
        basic_tick_ff && !core_ovf && first_aux_mode_field == aux_timer_pkg::MODE_RELOAD &&
        first_aux_input_select_field[2] |=> !pend_ff[0];
    endproperty
    a_sw_latch: assert property (p_sw_latch) else $error("reload without overflow");

    property p_single_edge;
        core_ovf && core_toggle_latch && first_aux_mode_field == aux_timer_pkg::MODE_RELOAD &&
        first_aux_input_select_field == 3'h5 |=> !pend_ff[0];
    endproperty
    a_single_edge: assert property (p_single_edge) else $error("rise-only reload on fall");

    property p_latch_irq;
        reload_latch |=> core_irq_flag;
    endproperty
    a_latch_irq: assert property (p_latch_irq) else $error("core irq not set on reload");
endmodule
`default_nettype wire

// File: aux_timer_pins.sv
// behavioural model of the trigger pins and an observer of the pwm pin
`timescale 1ns/100ps
`default_nettype none
module aux_timer_pins (
    // clock
    input wire logic clock,
    // pwm pin from the block
    input wire logic core_toggle_output_pin,
    // trigger pins into the block
    output logic first_aux_input_pin,
    output logic second_aux_input_pin,
    // rising edges seen on the pwm pin
    output logic [15:0] pwm_rises = 16'h0000
);
    // two basic periods at the slowest prescale plus the synchroniser delay
    localparam int HOLD_CLOCKS = 72;
    logic pwm_q = 1'b0;

    initial
    begin
        first_aux_input_pin = 1'b0;
        second_aux_input_pin = 1'b0;
    end

    always @(posedge clock)
    begin
        if (core_toggle_output_pin === 1'b1 && pwm_q === 1'b0)
            pwm_rises <= pwm_rises + 16'h0001;
        pwm_q <= core_toggle_output_pin;
    end

    // pins stay inputs all run; each level is held long enough to be sampled twice
    task automatic drive(input logic second, input logic level);
        @(negedge clock);
        if (second)
            second_aux_input_pin = level;
        else
            first_aux_input_pin = level;
        repeat (HOLD_CLOCKS) @(negedge clock);
    endtask
endmodule
`default_nettype wire

// File: aux_timer_reload_capture_tb.sv
// self-checking testbench for the auxiliary timer reload and capture block
`timescale 1ns/100ps
`default_nettype none
`define CHECK(what, exp, got) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            err_count++; \
            $display("BAD %s expected %h seen %h", what, exp, got); \
        end \
    end
module aux_timer_reload_capture_tb;
    logic clock = 1'b0, rst = 1'b1, core_run = 1'b0, core_count_down = 1'b0, core_output_enable = 1'b0;
    logic [1:0] block_prescale_field = 2'h0;
    logic [2:0] core_input_select = 3'h0, first_aux_mode_field = 3'h0, second_aux_mode_field = 3'h0;
    logic [2:0] first_aux_input_select_field = 3'h0, second_aux_input_select_field = 3'h0;
    logic first_aux_run_flag = 1'b0, second_aux_run_flag = 1'b0, latch_wr = 1'b0, latch_wdata = 1'b0;
    logic core_wr = 1'b0, first_aux_wr = 1'b0, second_aux_wr = 1'b0;
    logic [15:0] core_wdata = 16'h0000, first_aux_wdata = 16'h0000, second_aux_wdata = 16'h0000;
    logic core_irq_clr = 1'b0, first_aux_irq_clr = 1'b0, second_aux_irq_clr = 1'b0;
    wire logic first_aux_input_pin, second_aux_input_pin, core_toggle_output_pin;
    wire logic core_toggle_latch, core_irq_flag, first_aux_irq_flag, second_aux_irq_flag;
    wire logic [15:0] core_timer, first_aux_timer, second_aux_timer, pwm_rises;
    logic [15:0] prev_core = 16'h0000, jump_val = 16'h0000, jump_prev = 16'h0000, cap_val = 16'h0000, snap;
    logic [15:0] snap2;
    logic prev_latch = 1'b0, prev_oe = 1'b0, prev_irq = 1'b0;
    int cyc = 0, last_cyc = 0, interval = 0, jumps = 0, toggles = 0, err_count = 0, cmp_count = 0;
    logic [1:0] bps_codes [4] = '{aux_timer_pkg::BPS_DIV4, aux_timer_pkg::BPS_DIV8,
        aux_timer_pkg::BPS_DIV16, aux_timer_pkg::BPS_DIV32};
    logic [1:0] cap_edge [4] = '{aux_timer_pkg::EDGE_RISE, aux_timer_pkg::EDGE_FALL,
        aux_timer_pkg::EDGE_FALL, aux_timer_pkg::EDGE_ANY};
    logic cap_level [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic cap_hit [4] = '{1'b1, 1'b1, 1'b0, 1'b1};

    aux_timer_reload_capture i_aux_timer_reload_capture (.clock(clock), .rst(rst),
        .block_prescale_field(block_prescale_field), .core_input_select(core_input_select),
        .core_run(core_run), .core_count_down(core_count_down), .core_output_enable(core_output_enable),
        .first_aux_mode_field(first_aux_mode_field), .first_aux_input_select_field(first_aux_input_select_field),
        .first_aux_run_flag(first_aux_run_flag), .second_aux_mode_field(second_aux_mode_field),
        .second_aux_input_select_field(second_aux_input_select_field), .second_aux_run_flag(second_aux_run_flag),
        .core_wr(core_wr), .core_wdata(core_wdata), .first_aux_wr(first_aux_wr), .first_aux_wdata(first_aux_wdata),
        .second_aux_wr(second_aux_wr), .second_aux_wdata(second_aux_wdata), .latch_wr(latch_wr),
        .latch_wdata(latch_wdata), .core_irq_clr(core_irq_clr), .first_aux_irq_clr(first_aux_irq_clr),
        .second_aux_irq_clr(second_aux_irq_clr), .first_aux_input_pin(first_aux_input_pin),
        .second_aux_input_pin(second_aux_input_pin), .core_toggle_output_pin(core_toggle_output_pin),
        .core_timer(core_timer), .first_aux_timer(first_aux_timer), .second_aux_timer(second_aux_timer),
        .core_toggle_latch(core_toggle_latch), .core_irq_flag(core_irq_flag),
        .first_aux_irq_flag(first_aux_irq_flag), .second_aux_irq_flag(second_aux_irq_flag));

    aux_timer_pins i_aux_timer_pins (.clock(clock), .core_toggle_output_pin(core_toggle_output_pin),
        .first_aux_input_pin(first_aux_input_pin), .second_aux_input_pin(second_aux_input_pin),
        .pwm_rises(pwm_rises));

    initial
    begin
        forever #25 clock = ~clock;
    end

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // sampled just after the falling edge, so stimulus of that edge has landed
    always @(negedge clock)
    begin
        #1;
        cyc = cyc + 1;
        if (core_timer !== prev_core)
        begin
            interval = cyc - last_cyc;
            last_cyc = cyc;
            if (core_timer !== prev_core + 16'h0001)
            begin
                jumps = jumps + 1;
                jump_prev = jump_val;
                jump_val = core_timer;
            end
        end
        if (core_toggle_latch !== prev_latch)
            toggles = toggles + 1;
        if (first_aux_irq_flag === 1'b1 && prev_irq === 1'b0)
            cap_val = first_aux_timer;
        if (cyc > 14)
            `CHECK("output pin", prev_latch & prev_oe, core_toggle_output_pin)
        prev_core = core_timer;
        prev_latch = core_toggle_latch;
        prev_oe = core_output_enable;
        prev_irq = first_aux_irq_flag;
        if (cyc == 40000)
        begin
            err_count++;
            finish_test();
        end
    end

    // which: 0 core, 1 first aux, 2 second aux; software jumps are not counted
    task automatic write_reg(input int which, input logic [15:0] val);
        @(negedge clock);
        core_wr = (which == 0);
        first_aux_wr = (which == 1);
        second_aux_wr = (which == 2);
        core_wdata = val;
        first_aux_wdata = val;
        second_aux_wdata = val;
        @(negedge clock);
        core_wr = 1'b0;
        first_aux_wr = 1'b0;
        second_aux_wr = 1'b0;
        @(negedge clock);
        jumps = 0;
    endtask

    task automatic clear_irqs;
        @(negedge clock);
        {core_irq_clr, first_aux_irq_clr, second_aux_irq_clr} = 3'h7;
        @(negedge clock);
        {core_irq_clr, first_aux_irq_clr, second_aux_irq_clr} = 3'h0;
    endtask

    task automatic measure(input logic [1:0] bps, input logic [2:0] sel, input int exp_clocks);
        @(negedge clock);
        block_prescale_field = bps;
        core_input_select = sel;
        repeat (3 * exp_clocks + 4) @(negedge clock);
        `CHECK("count interval", exp_clocks, interval)
    endtask

    // extra clocks let the reload that follows the last overflow land
    task automatic wait_toggles(input int n);
        toggles = 0;
        jumps = 0;
        for (int k = 0; k < 8000 && toggles < n; k++) @(negedge clock);
        repeat (8) @(negedge clock);
    endtask

    initial
    begin
        repeat (12) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        `CHECK("reset state", 53'h0, {core_timer, first_aux_timer, second_aux_timer, core_toggle_latch,
            core_irq_flag, first_aux_irq_flag, second_aux_irq_flag, core_toggle_output_pin})
        core_run = 1'b1;
        measure(block_prescale_field, 3'h0, 8);
        for (int i = 0; i < 4; i++) measure(bps_codes[i], 3'h0, 4 << i);
        measure(aux_timer_pkg::BPS_DIV4, 3'h2, 16);
        core_run = 1'b0;
        first_aux_run_flag = 1'b1;
        second_aux_run_flag = 1'b1;
        repeat (40) @(negedge clock);
        `CHECK("aux counts", 1'b1, first_aux_timer != 16'h0000)
        first_aux_mode_field = aux_timer_pkg::MODE_RELOAD;
        second_aux_mode_field = aux_timer_pkg::MODE_CAPTURE;
        repeat (4) @(negedge clock);
        snap = first_aux_timer;
        snap2 = second_aux_timer;
        repeat (100) @(negedge clock);
        `CHECK("reload aux stopped", snap, first_aux_timer)
        `CHECK("capture aux stopped", snap2, second_aux_timer)
        {first_aux_run_flag, second_aux_run_flag} = 2'h0;
        first_aux_mode_field = aux_timer_pkg::MODE_CAPTURE;
        for (int i = 0; i < 4; i++)
        begin
            first_aux_input_select_field = {1'b0, cap_edge[i]};
            write_reg(0, 16'h1000 + 16'(i));
            clear_irqs();
            i_aux_timer_pins.drive(1'b0, cap_level[i]);
            `CHECK("capture flag", cap_hit[i], first_aux_irq_flag)
            if (cap_hit[i])
                `CHECK("captured value", 16'h1000 + 16'(i), cap_val)
        end
        first_aux_mode_field = aux_timer_pkg::MODE_TIMER;
        second_aux_input_select_field = 3'h1;
        write_reg(0, 16'h2000);
        i_aux_timer_pins.drive(1'b1, 1'b1);
        `CHECK("second capture", 17'h1_2000, {second_aux_irq_flag, second_aux_timer})
        second_aux_mode_field = aux_timer_pkg::MODE_RELOAD;
        second_aux_input_select_field = 3'h3;
        write_reg(2, 16'hABCD);
        write_reg(0, 16'h0000);
        clear_irqs();
        i_aux_timer_pins.drive(1'b1, 1'b0);
        `CHECK("pin reload", 16'hABCD, core_timer)
        `CHECK("pin reload flags", 2'h1, {core_irq_flag, second_aux_irq_flag})
        second_aux_mode_field = aux_timer_pkg::MODE_TIMER;
        first_aux_mode_field = aux_timer_pkg::MODE_RELOAD;
        first_aux_input_select_field = 3'h7;
        write_reg(1, 16'hFFF0);
        write_reg(0, 16'h0100);
        clear_irqs();
        for (int i = 0; i < 2; i++)
        begin
            @(negedge clock);
            latch_wdata = ~latch_wdata;
            latch_wr = 1'b1;
            @(negedge clock);
            latch_wr = 1'b0;
            repeat (40) @(negedge clock);
        end
        `CHECK("latch write no reload", 18'h00100, {jumps[1:0], core_timer})
        `CHECK("latch write no flag", 1'b0, first_aux_irq_flag)
        block_prescale_field = aux_timer_pkg::BPS_DIV4;
        core_input_select = 3'h0;
        write_reg(0, 16'hFFF0);
        core_run = 1'b1;
        wait_toggles(6);
        `CHECK("reloads per overflow", 6, jumps)
        `CHECK("reload value", 16'hFFF0, jump_val)
        `CHECK("latch reload flags", 2'h3, {core_irq_flag, first_aux_irq_flag})
        first_aux_input_select_field = 3'h5;
        second_aux_mode_field = aux_timer_pkg::MODE_RELOAD;
        second_aux_input_select_field = 3'h6;
        write_reg(2, 16'hFF80);
        core_output_enable = 1'b1;
        snap = pwm_rises;
        wait_toggles(6);
        `CHECK("alternating reloads", 6, jumps)
        `CHECK("alternating sources", 16'h0070, jump_prev ^ jump_val)
        `CHECK("pwm pin active", 1'b1, pwm_rises != snap)
        core_output_enable = 1'b0;
        repeat (4) @(negedge clock);
        snap = pwm_rises;
        repeat (1200) @(negedge clock);
        `CHECK("pwm pin gated", snap, pwm_rises)
        first_aux_input_select_field = 3'h7;
        second_aux_input_select_field = 3'h7;
        wait_toggles(4);
        `CHECK("same trigger winner", 32'hFF80_FF80, {jump_prev, jump_val})
        core_count_down = 1'b1;
        write_reg(0, 16'h0001);
        clear_irqs();
        wait_toggles(1);
        `CHECK("underflow reload", 1'b1, core_timer inside {[16'hFF70:16'hFF80]})
        `CHECK("underflow flags", 2'h3, {core_irq_flag, second_aux_irq_flag})
        finish_test();
    end
endmodule
`default_nettype wire
